/* File: shared/usart_cfg_map.vh */
// Purpose: Register indices, field positions, reset values and codes
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef USART_CFG_MAP_VH
`define USART_CFG_MAP_VH

// Register indices
`define RX_CTRL_IDX 6'h06
`define FRAME_CTRL_IDX 6'h07
`define BAUD_LO_IDX 6'h08
`define BAUD_HI_IDX 6'h09
`define DEBUG_CTRL_IDX 6'h0B
`define IR_EVENT_IDX 6'h0C
`define IR_PULSE_LEN_IDX 6'h0D
`define STATUS_IDX 6'h10

// Reset values
`define RX_CTRL_RST 8'h00
`define FRAME_CTRL_RST 8'h03
`define BAUD_RST 16'h0000
`define DEBUG_CTRL_RST 8'h00
`define IR_EVENT_RST 8'h00
`define IR_PULSE_LEN_RST 8'h00

// Receiver control fields
`define RXC_RX_EN 7
`define RXC_TX_EN 6
`define RXC_MODE_HI 2
`define RXC_MODE_LO 1
`define RXC_MULTIPROC 0

// Frame control fields
`define FC_COMM_HI 7
`define FC_COMM_LO 6
`define FC_PAR_HI 5
`define FC_PAR_LO 4
`define FC_STOP 3
`define FC_SIZE_HI 2
`define FC_SIZE_LO 0
`define FC_ORDER 2
`define FC_PHASE 1
`define FC_SPI_VIEW_MASK 8'hC6

// Single-bit control and status fields
`define DBG_RUN_BIT 0
`define IR_EI_BIT 0
`define ST_PAR_ERR_BIT 0
`define ST_RUN_BIT 1

// Mode codes
`define RXM_NORMAL 2'h0
`define RXM_DOUBLE 2'h1
`define RXM_GENERIC 2'h2
`define RXM_LIN 2'h3
`define CM_ASYNC 2'h0
`define CM_SYNC 2'h1
`define CM_IR 2'h2
`define CM_SPI_MASTER 2'h3
`define PM_OFF 2'h0
`define PM_RSVD 2'h1
`define PM_EVEN 2'h2
`define PM_ODD 2'h3
`define CS_9_LOW 3'h6
`define CS_9_HIGH 3'h7

// Timing counts in sample ticks, and the pulse length pass code
`define OVS_NORMAL 5'h10
`define OVS_DOUBLE 5'h08
`define IR_PULSE_SAMPLES 4'h3
`define PULSE_LEN_PASS 8'hFF
`endif

/* File: rtl/ir_tx_pulse.v */
// Purpose: Infrared transmit pulse shaper
// Assumes: Ticks are one-cycle pulses on mclk
// Notes: A zero bit is sent as one high pulse, a one bit as no pulse
`timescale 1ns/1ps
`include "usart_cfg_map.vh"
module ir_tx_pulse #(
  parameter PLW = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire enable,
  input wire run,
  input wire tx_bit,
  input wire bit_tick,
  input wire sample_tick,
  input wire [PLW-1:0] pulse_len,
  output reg ir_tx
);
  reg active_ff;
  reg nxt_active;
  reg [PLW-1:0] clk_cnt_ff;
  reg [3:0] smp_cnt_ff;
  wire use_samples;
  wire passthru;
  wire start;

  assign use_samples = (pulse_len == {PLW{1'b0}});
  assign passthru = ~enable | (pulse_len == `PULSE_LEN_PASS);
  assign start = bit_tick & ~tx_bit;

  // Next pulse state; the pin copies it, so width equals the count
  always @* begin
    nxt_active = active_ff;
    if (passthru | ~run)
      nxt_active = 1'b0;
    else if (start)
      nxt_active = 1'b1; // [R20]
    else if (active_ff & use_samples) begin
      if (sample_tick & (smp_cnt_ff == 4'h1))
        nxt_active = 1'b0; // [R18]
    end else if (active_ff & (clk_cnt_ff == {PLW{1'b0}})) begin
      nxt_active = 1'b0; // [R19]
    end
  end

  // Counters load at the pulse start and run down while it lasts
  always @(posedge mclk) begin
    if (sys_rst) begin
      active_ff <= 1'b0;
      clk_cnt_ff <= {PLW{1'b0}};
      smp_cnt_ff <= 4'h0;
    end else begin
      active_ff <= nxt_active;
      if (start) begin
        clk_cnt_ff <= pulse_len - {{(PLW-1){1'b0}}, 1'b1};
        smp_cnt_ff <= `IR_PULSE_SAMPLES;
      end else if (active_ff) begin
        if (sample_tick)
          smp_cnt_ff <= smp_cnt_ff - 4'h1;
        if (clk_cnt_ff != {PLW{1'b0}})
          clk_cnt_ff <= clk_cnt_ff - {{(PLW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Registered output so the pin never glitches
  always @(posedge mclk) begin
    if (sys_rst)
      ir_tx <= 1'b1;
    else if (passthru)
      ir_tx <= tx_bit; // [R21]
    else
      ir_tx <= nxt_active;
  end
endmodule

/* File: rtl/usart_cfg.v */
// Purpose: Serial transceiver configuration, baud prescaler and IR stage
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: Shift engines sit outside and use the decoded outputs
// Summary of operation
// R1 - Mode code 3 is LIN constrained autobaud
// R2 - Codes 0,1,2: normal, double speed, generic
// R3 - Multiprocessor mode drops non-address receive frames
// R4 - Comm mode: async, sync, infrared, master SPI
// R5 - Master SPI reinterprets low frame control bits
// R6 - Even/odd parity generated for transmit data
// R7 - Receive parity mismatch raises parity error flag
// R8 - Reserved parity code acts as disabled
// R9 - Stop bit field: one or two, transmit only
// R10 - Shared character size, nine-bit byte order
// R11 - Bit order: 0 MSB first, 1 LSB
// R12 - Software keeps bit order during transfers
// R13 - Clock phase picks leading or trailing sample
// R14 - Divisor low byte at base, high next
// R15 - Divisor write reloads prescaler immediately
// R16 - Debug run clear halts block and events
// R17 - Event enable takes IR receive from event
// R18 - Pulse length zero gives 3/16 bit pulse
// R19 - Pulse length 1..254 gives clock-count pulse
// R20 - IR pulse starts on baud bit tick
// R21 - Pulse length 255 passes signals unchanged
// R22 - Software sets pulse length before transmitter enable
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "usart_cfg_map.vh"
module usart_cfg #(
  parameter AW = 8,
  parameter BW = 16
) (
  input wire mclk,
  input wire sys_rst,
  input wire hsel,
  input wire [AW-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire debug_halt,
  input wire rxd_pin,
  input wire event_in,
  input wire tx_raw,
  output wire txd_pin,
  output wire rx_line,
  input wire [8:0] tx_data,
  output reg tx_parity_bit,
  input wire rx_frame_done,
  input wire [8:0] rx_data,
  input wire rx_parity_bit,
  input wire rx_addr_bit,
  output reg rx_frame_accept,
  output wire [1:0] comm_mode,
  output wire master_spi_mode,
  output wire infrared_mode,
  output wire lin_constrained_autobaud,
  output wire generic_autobaud,
  output wire double_speed,
  output wire multiprocessor_mode,
  output wire parity_enable,
  output wire parity_odd,
  output wire stop_two,
  output wire [3:0] data_bits,
  output wire nine_low_first,
  output wire bit_order,
  output wire clock_phase,
  output wire transmitter_enable,
  output wire receiver_enable,
  output wire run,
  output reg sample_tick,
  output reg bit_tick
);
  // Registers
  reg [7:0] rx_ctrl_ff;
  reg [7:0] frame_ctrl_ff;
  reg [BW-1:0] baud_ff;
  reg [7:0] debug_ctrl_ff;
  reg [7:0] ir_event_ff;
  reg [7:0] tx_pulse_length_ff;
  reg parity_error_flag_ff;
  reg nxt_parity_error_flag;
  // Bus phase state
  reg a_valid_ff;
  reg a_write_ff;
  reg [5:0] a_idx_ff;
  reg [31:0] rd_mux;
  wire addr_take;
  wire addr_ok;
  wire wr_en;
  // Prescaler
  reg [BW-1:0] presc_ff;
  reg [4:0] samp_ff;
  reg baud_reload;
  wire [4:0] ovs;
  // Synchronisers
  reg [1:0] halt_sync_ff;
  reg [1:0] rxd_sync_ff;
  reg [1:0] evt_sync_ff;
  reg evt_hold_ff;
  wire [2:0] char_size;
  wire [1:0] rx_mode_a;
  wire [1:0] parity_mode;
  wire rx_parity_calc;
  wire infrared_event_input_enable;
  wire debug_run;

  // Parity over the active data bits only
  function par9;
    input [8:0] d;
    input [3:0] n;
    integer i;
    reg p;
    begin
      p = 1'b0;
      for (i = 0; i < 9; i = i + 1)
        if (i < n)
          p = p ^ d[i];
      par9 = p;
    end
  endfunction

  // Character size code to bit count, reserved codes fall back to 8
  function [3:0] size_bits;
    input [2:0] c;
    begin
      case (c)
        3'h0: size_bits = 4'h5;
        3'h1: size_bits = 4'h6;
        3'h2: size_bits = 4'h7;
        3'h6: size_bits = 4'h9;
        3'h7: size_bits = 4'h9;
        default: size_bits = 4'h8;
      endcase
    end
  endfunction

  // Field decode
  assign comm_mode = frame_ctrl_ff[`FC_COMM_HI:`FC_COMM_LO]; // [R4]
  assign master_spi_mode = (comm_mode == `CM_SPI_MASTER);
  assign infrared_mode = (comm_mode == `CM_IR);
  assign rx_mode_a = rx_ctrl_ff[`RXC_MODE_HI:`RXC_MODE_LO];
  assign lin_constrained_autobaud = (rx_mode_a == `RXM_LIN); // [R1]
  assign generic_autobaud = (rx_mode_a == `RXM_GENERIC); // [R2]
  assign double_speed = (rx_mode_a == `RXM_DOUBLE); // [R2]
  assign multiprocessor_mode = rx_ctrl_ff[`RXC_MULTIPROC];
  assign transmitter_enable = rx_ctrl_ff[`RXC_TX_EN];
  assign receiver_enable = rx_ctrl_ff[`RXC_RX_EN];
  assign debug_run = debug_ctrl_ff[`DBG_RUN_BIT];
  assign infrared_event_input_enable = ir_event_ff[`IR_EI_BIT];

  // Low bits mean different things in master SPI mode
  assign parity_mode = frame_ctrl_ff[`FC_PAR_HI:`FC_PAR_LO];
  assign char_size = frame_ctrl_ff[`FC_SIZE_HI:`FC_SIZE_LO];
  // Reserved code 1 is treated as off
  assign parity_enable = ~master_spi_mode & parity_mode[1]; // [R5] [R8]
  assign parity_odd = parity_mode == `PM_ODD; // [R6]
  assign stop_two = ~master_spi_mode & frame_ctrl_ff[`FC_STOP]; // [R9]
  assign data_bits = master_spi_mode ? 4'h8 : size_bits(char_size); // [R10]
  assign nine_low_first = ~master_spi_mode & (char_size == `CS_9_LOW); // [R10]
  assign bit_order = master_spi_mode & frame_ctrl_ff[`FC_ORDER]; // [R11]
  assign clock_phase = master_spi_mode & frame_ctrl_ff[`FC_PHASE]; // [R13]

  // Debug halt comes from another domain
  always @(posedge mclk) begin
    if (sys_rst)
      halt_sync_ff <= 2'b00;
    else
      halt_sync_ff <= {halt_sync_ff[0], debug_halt};
  end
  assign run = debug_run | ~halt_sync_ff[1]; // [R16]

  // Receive pin and event input synchronisers
  always @(posedge mclk) begin
    if (sys_rst) begin
      rxd_sync_ff <= 2'b11;
      evt_sync_ff <= 2'b11;
      evt_hold_ff <= 1'b1;
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[0], rxd_pin};
      evt_sync_ff <= {evt_sync_ff[0], event_in};
      if (run)
        evt_hold_ff <= evt_sync_ff[1]; // [R16]
    end
  end

  // Event source only in IR mode; pin ignored then
  assign rx_line = (infrared_mode & infrared_event_input_enable) ?
                   evt_hold_ff : rxd_sync_ff[1]; // [R17]

  // Transmit parity, combined with the odd/even choice
  always @(posedge mclk) begin
    if (sys_rst)
      tx_parity_bit <= 1'b0;
    else
      tx_parity_bit <= parity_enable &
                       (par9(tx_data, data_bits) ^ parity_odd); // [R6]
  end

  // Receive frame filter and parity check
  assign rx_parity_calc = par9(rx_data, data_bits) ^ parity_odd;
  always @(posedge mclk) begin
    if (sys_rst)
      rx_frame_accept <= 1'b0;
    else
      rx_frame_accept <= rx_frame_done & run &
                         (~multiprocessor_mode | rx_addr_bit); // [R3]
  end

  // AHB address phase
  assign addr_take = hsel & hready & htrans[1];
  assign addr_ok = (haddr[1:0] == 2'b00) & (hsize == 3'b010);
  assign wr_en = a_valid_ff & a_write_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always @(posedge mclk) begin
    if (sys_rst) begin
      a_valid_ff <= 1'b0;
      a_write_ff <= 1'b0;
      a_idx_ff <= 6'h00;
    end else if (hready) begin
      a_valid_ff <= addr_take & addr_ok;
      a_write_ff <= hwrite;
      a_idx_ff <= haddr[7:2];
    end
  end

  // Register writes in the data phase
  always @(posedge mclk) begin
    if (sys_rst) begin
      rx_ctrl_ff <= `RX_CTRL_RST;
      frame_ctrl_ff <= `FRAME_CTRL_RST;
      baud_ff <= `BAUD_RST;
      debug_ctrl_ff <= `DEBUG_CTRL_RST;
      ir_event_ff <= `IR_EVENT_RST;
      tx_pulse_length_ff <= `IR_PULSE_LEN_RST;
    end else if (wr_en) begin
      case (a_idx_ff)
        `RX_CTRL_IDX: rx_ctrl_ff <= hwdata[7:0] & 8'hC7;
        `FRAME_CTRL_IDX: frame_ctrl_ff <= hwdata[7:0];
        `BAUD_LO_IDX: baud_ff[7:0] <= hwdata[7:0]; // [R14]
        `BAUD_HI_IDX: baud_ff[BW-1:8] <= hwdata[BW-9:0]; // [R14]
        `DEBUG_CTRL_IDX: debug_ctrl_ff <= hwdata[7:0] & 8'h01;
        `IR_EVENT_IDX: ir_event_ff <= hwdata[7:0] & 8'h01;
        `IR_PULSE_LEN_IDX: tx_pulse_length_ff <= hwdata[7:0];
        default: rx_ctrl_ff <= rx_ctrl_ff;
      endcase
    end
  end

  // Parity error: hardware set wins over a write-one clear
  always @* begin
    nxt_parity_error_flag = parity_error_flag_ff;
    if (wr_en & (a_idx_ff == `STATUS_IDX) & hwdata[`ST_PAR_ERR_BIT])
      nxt_parity_error_flag = 1'b0;
    if (rx_frame_done & run & parity_enable &
        (~multiprocessor_mode | rx_addr_bit) &
        (rx_parity_calc != rx_parity_bit))
      nxt_parity_error_flag = 1'b1; // [R7]
  end
  always @(posedge mclk) begin
    if (sys_rst)
      parity_error_flag_ff <= 1'b0;
    else
      parity_error_flag_ff <= nxt_parity_error_flag;
  end

  // Read mux; master SPI view hides the async fields
  always @* begin
    rd_mux = 32'h0000_0000;
    case (a_idx_ff)
      `RX_CTRL_IDX: rd_mux[7:0] = rx_ctrl_ff;
      `FRAME_CTRL_IDX:
        rd_mux[7:0] = master_spi_mode ?
                      (frame_ctrl_ff & `FC_SPI_VIEW_MASK) : frame_ctrl_ff; // [R5]
      `BAUD_LO_IDX: rd_mux[7:0] = baud_ff[7:0];
      `BAUD_HI_IDX: rd_mux[BW-9:0] = baud_ff[BW-1:8];
      `DEBUG_CTRL_IDX: rd_mux[7:0] = debug_ctrl_ff;
      `IR_EVENT_IDX: rd_mux[7:0] = ir_event_ff;
      `IR_PULSE_LEN_IDX: rd_mux[7:0] = tx_pulse_length_ff;
      `STATUS_IDX: begin
        rd_mux[`ST_PAR_ERR_BIT] = parity_error_flag_ff;
        rd_mux[`ST_RUN_BIT] = run;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Register mux, stable for the whole data phase
  assign hrdata = (a_valid_ff & ~a_write_ff) ? rd_mux : 32'h0000_0000;

  // Divisor write restarts the prescaler at once
  always @* begin
    baud_reload = wr_en &
                  ((a_idx_ff == `BAUD_LO_IDX) | (a_idx_ff == `BAUD_HI_IDX));
  end

  // Oversampling halves only for async double speed
  assign ovs = (double_speed & (comm_mode == `CM_ASYNC)) ?
               `OVS_DOUBLE : `OVS_NORMAL; // [R2]

  // Prescaler: sample tick every divisor+1 clocks; frozen on halt
  always @(posedge mclk) begin
    if (sys_rst) begin
      presc_ff <= {BW{1'b0}};
      samp_ff <= 5'h00;
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else if (baud_reload) begin
      presc_ff <= {BW{1'b0}}; // [R15]
      samp_ff <= 5'h00;
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else if (~run) begin
      sample_tick <= 1'b0; // [R16]
      bit_tick <= 1'b0;
    end else if (presc_ff >= baud_ff) begin
      presc_ff <= {BW{1'b0}};
      sample_tick <= 1'b1;
      if (samp_ff >= ovs - 5'h01) begin
        samp_ff <= 5'h00;
        bit_tick <= 1'b1;
      end else begin
        samp_ff <= samp_ff + 5'h01;
        bit_tick <= 1'b0;
      end
    end else begin
      presc_ff <= presc_ff + {{(BW-1){1'b0}}, 1'b1};
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
    end
  end

  // IR shaping acts only in infrared mode; else transmit passes
  // Pulse length is read live, so it must be set before enabling
  ir_tx_pulse #(
    .PLW(8)
  ) u_ir_tx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(infrared_mode), // [R18] [R22]
    .run(run),
    .tx_bit(tx_raw),
    .bit_tick(bit_tick),
    .sample_tick(sample_tick),
    .pulse_len(tx_pulse_length_ff),
    .ir_tx(txd_pin)
  );
endmodule

/* File: tb/usart_cfg_asserts.sv */
// Purpose: Port checker for the serial configuration block
// Assumes: One clock, synchronous reset
// Notes: Bound to every usart_cfg
`timescale 1ns/1ps
module usart_cfg_asserts (
  input wire mclk,
  input wire sys_rst,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire rxd_pin,
  input wire tx_raw,
  input wire txd_pin,
  input wire rx_line,
  input wire [8:0] tx_data,
  input wire tx_parity_bit,
  input wire rx_frame_done,
  input wire rx_addr_bit,
  input wire rx_frame_accept,
  input wire [1:0] comm_mode,
  input wire master_spi_mode,
  input wire infrared_mode,
  input wire lin_constrained_autobaud,
  input wire generic_autobaud,
  input wire double_speed,
  input wire multiprocessor_mode,
  input wire parity_enable,
  input wire parity_odd,
  input wire [3:0] data_bits,
  input wire run,
  input wire sample_tick,
  input wire bit_tick
);
  reg rph_ff;
  reg exp_par_ff;
  function automatic logic par(input logic [8:0] d, input logic [3:0] n);
    par = ^(d & ~(9'h1ff << n));
  endfunction
  // Read data phase and expected parity, from inputs only
  always @(posedge mclk) begin
    rph_ff <= !sys_rst && hsel && hready && htrans[1] && !hwrite;
    exp_par_ff <= !sys_rst && parity_enable && (par(tx_data, data_bits) ^ parity_odd);
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_idle_rdata: assert property (!rph_ff |-> hrdata == 32'h0000_0000)
    else $error("read data outside read phase");
  a_parity_gen: assert property (tx_parity_bit == exp_par_ff)
    else $error("transmit parity bit wrong");
  a_mode_decode: assert property (master_spi_mode == (comm_mode == 2'h3) &&
    infrared_mode == (comm_mode == 2'h2)) else $error("comm mode decode wrong");
  a_rx_modes: assert property (lin_constrained_autobaud |-> !generic_autobaud &&
    !double_speed) else $error("receiver modes overlap");
  a_addr_accept: assert property (rx_frame_done && run &&
    (!multiprocessor_mode || rx_addr_bit) |=> rx_frame_accept) else $error("frame not taken");
  a_addr_drop: assert property (rx_frame_done && (!run || multiprocessor_mode &&
    !rx_addr_bit) |=> !rx_frame_accept) else $error("frame taken wrongly");
  a_tx_pass: assert property (!infrared_mode |=> txd_pin == $past(tx_raw))
    else $error("transmit line altered outside infrared");
  a_pulse_align: assert property (infrared_mode && $rose(txd_pin) && !$past(tx_raw)
    |-> $past(bit_tick) || $past(bit_tick, 2)) else $error("pulse not on bit tick");
  a_halt_ticks: assert property (!run && !$past(run) |-> !sample_tick && !bit_tick)
    else $error("ticks while halted");
  a_rx_sync: assert property (!infrared_mode |-> rx_line == $past(rxd_pin, 2))
    else $error("receive line not from pin");
  c_accept: cover property (rx_frame_accept);
  c_ir_pulse: cover property (infrared_mode && $rose(txd_pin));
  c_halt: cover property (!run && rx_frame_done);
endmodule
bind usart_cfg usart_cfg_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .rxd_pin(rxd_pin), .tx_raw(tx_raw), .txd_pin(txd_pin), .rx_line(rx_line),
  .tx_data(tx_data), .tx_parity_bit(tx_parity_bit), .rx_frame_done(rx_frame_done),
  .rx_addr_bit(rx_addr_bit), .rx_frame_accept(rx_frame_accept), .comm_mode(comm_mode),
  .master_spi_mode(master_spi_mode), .infrared_mode(infrared_mode),
  .lin_constrained_autobaud(lin_constrained_autobaud), .generic_autobaud(generic_autobaud),
  .double_speed(double_speed), .multiprocessor_mode(multiprocessor_mode),
  .parity_enable(parity_enable), .parity_odd(parity_odd), .data_bits(data_bits),
  .run(run), .sample_tick(sample_tick), .bit_tick(bit_tick));

/* File: tb/remote_node.sv */
// Purpose: Remote node sending frames on the receive pin
// Assumes: Start bit, eight data bits, stop bit
// Notes: Line idles high as with a pull-up
`timescale 1ns/1ps
module remote_node (
  input wire mclk,
  input wire sys_rst,
  output logic rxd_pin
);
  logic [9:0] sh_ff;
  int cnt;
  int nb;
  // Random idle gaps give both prompt and slow frames
  always @(posedge mclk) begin
    if (sys_rst) begin
      rxd_pin <= 1'b1;
      cnt = 0;
      nb = 0;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
    end else if (nb > 0) begin
      rxd_pin <= sh_ff[0];
      sh_ff <= sh_ff >> 1;
      nb = nb - 1;
      cnt = 39;
    end else begin
      sh_ff <= {1'b1, 8'($urandom), 1'b0};
      nb = 10;
      cnt = $urandom_range(0, 60);
    end
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the serial configuration block
// Assumes: Zero wait state bus, remote node on the receive pin
// Notes: Reads are checked from a queue in the data phase
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, rd_ph = 0, debug_halt = 0;
  logic event_in = 1, tx_raw = 1, rx_frame_done = 0, rx_parity_bit = 0, rx_addr_bit = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0;
  logic [8:0] tx_data = 0, rx_data = 0;
  logic [31:0] exp_q[$];
  logic [7:0] ra[9] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h2C, 8'h30, 8'h34, 8'h40, 8'hFC};
  logic [7:0] rv[9] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [7:0] pl[4] = '{8'h01, 8'h06, 8'hFE, 8'h00};
  int pw[4] = '{1, 6, 254, 60};
  wire hreadyout, txd_pin, rx_line, rxd_pin, lin, gen, dbl, msm, irm, pen, podd, stp2;
  wire nlf, bord, cph, ten, ren, run, stk, btk;
  wire [31:0] hrdata;
  wire [1:0] comm_mode;
  wire [3:0] data_bits;
  int n_fail = 0, cmp_count = 0, n;
  logic [7:0] v;
  usart_cfg dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(), .hrdata(hrdata), .debug_halt(debug_halt), .rxd_pin(rxd_pin), .event_in(event_in),
    .tx_raw(tx_raw), .txd_pin(txd_pin), .rx_line(rx_line), .tx_data(tx_data),
    .tx_parity_bit(), .rx_frame_done(rx_frame_done), .rx_data(rx_data),
    .rx_parity_bit(rx_parity_bit), .rx_addr_bit(rx_addr_bit), .rx_frame_accept(),
    .comm_mode(comm_mode), .master_spi_mode(msm), .infrared_mode(irm),
    .lin_constrained_autobaud(lin), .generic_autobaud(gen), .double_speed(dbl),
    .multiprocessor_mode(), .parity_enable(pen), .parity_odd(podd), .stop_two(stp2),
    .data_bits(data_bits), .nine_low_first(nlf), .bit_order(bord), .clock_phase(cph),
    .transmitter_enable(ten), .receiver_enable(ren), .run(run), .sample_tick(stk),
    .bit_tick(btk));
  remote_node peer (.mclk(mclk), .sys_rst(sys_rst), .rxd_pin(rxd_pin));
  always #50 mclk = ~mclk;
  // Random transmit data keeps the parity check busy
  always @(posedge mclk) tx_data <= 9'($urandom);
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Single transfer; address held until hready, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // Oldest note is compared while read data stands
  always @(negedge mclk) if (rd_ph) chk("hrdata", hrdata, exp_q.pop_front());
  task automatic cnt(input logic b, output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while ((b ? btk : stk) !== 1'b1);
  endtask
  task automatic pulse(output int c);
    cnt(1'b1, c);
    c = 0;
    do @(negedge mclk); while (txd_pin !== 1'b1);
    do begin
      @(negedge mclk);
      c++;
    end while (txd_pin === 1'b1);
  endtask
  task automatic rxf(input logic a, input logic [8:0] d, input logic p);
    @(posedge mclk);
    rx_frame_done <= 1'b1;
    rx_addr_bit <= a;
    rx_data <= d;
    rx_parity_bit <= p;
    @(posedge mclk);
    rx_frame_done <= 1'b0;
  endtask
  // Watchdog well beyond the expected run time
  initial begin
    #2000000;
    n_fail++;
    finish_test;
  end
  initial begin
    n = $urandom(32'ha99e);
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    v = 8'($urandom);
    bus(1'b1, 8'h24, v);
    rd(8'h24, v);
    bus(1'b1, 8'h24, 8'h00);
    bus(1'b1, 8'h20, 8'h13);
    cnt(1'b0, n);
    chk("first tick", n, 21);
    cnt(1'b0, n);
    chk("tick gap", n, 20);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h18, 8'(i * 2 + 128));
      @(negedge mclk);
      chk("rx mode", {ren, ten, lin, gen, dbl}, {2'h2, i == 3, i == 2, i == 1});
      cnt(1'b1, n);
      cnt(1'b1, n);
      if (i < 2) chk("bit gap", n, 320 >> i);
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h1C, {2'h0, i[1:0], i[0], i[2:0]});
      @(negedge mclk);
      chk("size", {nlf, data_bits}, {i == 6, i < 4 ? 4'(5 + i) : i < 6 ? 4'h8 : 4'h9});
      chk("parity", {pen, podd, stp2}, {i[1], i[1:0] == 2'h3, i[0]});
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h1C, {i[1:0], 6'h3F});
      @(negedge mclk);
      chk("comm_mode", {msm, irm, comm_mode}, {i == 3, i == 2, i[1:0]});
      rd(8'h1C, i == 3 ? 8'hC6 : {i[1:0], 6'h3F});
    end
    chk("spi fields", {bord, cph}, 2'h3);
    bus(1'b1, 8'h1C, 8'hC0);
    @(negedge mclk);
    chk("spi fields", {bord, cph}, 2'h0);
    bus(1'b1, 8'h1C, 8'h23);
    bus(1'b1, 8'h18, 8'h01);
    rxf(1'b1, 9'h003, 1'b1);
    rxf(1'b0, 9'h0A5, 1'b0);
    rd(8'h40, 8'h03);
    bus(1'b1, 8'h40, 8'h01);
    rxf(1'b1, 9'h0A5, 1'b0);
    rd(8'h40, 8'h02);
    tx_raw <= 1'b0;
    bus(1'b1, 8'h34, 8'h06);
    bus(1'b1, 8'h18, 8'h40);
    bus(1'b1, 8'h1C, 8'h83);
    chk("tx enable", {ren, ten}, 2'h1);
    foreach (pl[i]) begin
      bus(1'b1, 8'h34, pl[i]);
      pulse(n);
      chk("pulse", n, pw[i]);
    end
    bus(1'b1, 8'h34, 8'hFF);
    cnt(1'b1, n);
    repeat (3) @(negedge mclk);
    chk("pass", txd_pin, 1'b0);
    bus(1'b1, 8'h30, 8'h01);
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk);
      event_in <= j[0];
      repeat (4) @(negedge mclk);
      chk("event rx", rx_line, j[0]);
    end
    @(posedge mclk);
    debug_halt <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("halt", run, 1'b0);
    @(posedge mclk);
    event_in <= 1'b0;
    rxf(1'b1, 9'h003, 1'b1);
    repeat (4) @(negedge mclk);
    chk("frozen", rx_line, 1'b1);
    rd(8'h40, 8'h00);
    bus(1'b1, 8'h2C, 8'h01);
    @(negedge mclk);
    chk("debug run", run, 1'b1);
    finish_test;
  end
endmodule
